// file: hw/cia_channel_io.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - tag zero selects system space, tag one selects io space
// - io space uses low 16 pointer bits; system space uses all 20
// - base comes from pointer a, b, c, or the parameter block pointer
// - addressing mode adjustment is added to form the effective address
// - 8-bit bus: one cycle per byte, two per word, any alignment
// - 16-bit bus: one cycle for byte or even word, two for odd word
// - byte or word size comes from the opcode, not bus width
// - source operand reads the peripheral, destination operand writes it
// - move, and, or, bit clear, bit set, and jump on bit provided
// - transfers within and between both spaces, all addresses reachable
// - block dma limited to 64k bytes under byte-count termination
// - no instructions execute while block dma runs
// - exactly one instruction after dma entry, then dma mode
// - parameter block pointer accesses always go to system space
module cia_channel_io (
  input  wire logic                      I_CLK,
  input  wire logic                      I_RST,
  input  wire logic [cia_pkg::SYS_AW-1:0] I_PTR_REG_A,
  input  wire logic [cia_pkg::SYS_AW-1:0] I_PTR_REG_B,
  input  wire logic [cia_pkg::SYS_AW-1:0] I_PTR_REG_C,
  input  wire logic [2:0]                I_PTR_TAGS,
  input  wire logic [cia_pkg::SYS_AW-1:0] I_PARAM_BLOCK_PTR,
  input  wire cia_pkg::cia_cfg_t         I_CFG,
  input  wire logic                      I_INSTR_VALID,
  input  wire cia_pkg::cia_instr_t       I_INSTR,
  input  wire logic                      I_BUS_DONE,
  input  wire logic [cia_pkg::DW-1:0]    I_BUS_RDATA,
  input  wire logic                      I_DMA_DONE,
  input  wire logic [cia_pkg::BC_W:0]    I_DMA_COUNT,
  output logic                           O_INSTR_READY,
  output logic                           O_BUS_REQ,
  output cia_pkg::cia_bus_req_t          O_BUS,
  output logic                           O_JUMP_VALID,
  output logic                           O_JUMP_TAKEN,
  output logic                           O_DMA_ACTIVE,
  output logic                           O_DMA_LIMIT_ERR
);
  import cia_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RD    = 6'h02,
    ST_WR    = 6'h04,
    ST_DONE  = 6'h08,
    ST_DMA   = 6'h10,
    ST_ERR   = 6'h20
  } cia_state_t;

  // decides whether an access needs two cycles
  function automatic logic two_cycles(input logic bus16, input logic word, input logic a0);
    two_cycles = word & (~bus16 | a0);
  endfunction

  // builds one bus cycle of a possibly split access
  function automatic cia_bus_req_t mk_req(input logic io, input logic [SYS_AW-1:0] a,
                                         input logic wr, input logic bus16,
                                         input logic whole, input logic [DW-1:0] d);
    cia_bus_req_t r;
    r.io_space = io;
    r.addr     = a;
    r.write    = wr;
    r.word     = whole;
    r.upper    = bus16 & a[0] & ~whole;
    r.wdata    = (r.upper) ? {d[7:0], d[7:0]} : d;
    mk_req     = r;
  endfunction

  cia_state_t        state_reg, state_next;
  cia_instr_t        ins_reg, ins_next;
  logic              half_reg, half_next;       // second byte of a split word
  logic [DW-1:0]     data_reg, data_next;
  logic              armed_reg, armed_next;     // dma entry seen, one more to run
  logic              req_reg, req_next;
  cia_bus_req_t      bus_reg, bus_next;
  logic              jv_reg, jv_next, jt_reg, jt_next, err_reg, err_next;
  logic              src_io, dst_io;
  logic [SYS_AW-1:0] src_addr, dst_addr;

  cia_addr_gen u_src_ag (
    .i_ptr_a(I_PTR_REG_A), .i_ptr_b(I_PTR_REG_B), .i_ptr_c(I_PTR_REG_C),
    .i_tags(I_PTR_TAGS), .i_param_block_ptr(I_PARAM_BLOCK_PTR),
    .i_opnd(ins_reg.src), .o_io_space(src_io), .o_addr(src_addr)
  );
  cia_addr_gen u_dst_ag (
    .i_ptr_a(I_PTR_REG_A), .i_ptr_b(I_PTR_REG_B), .i_ptr_c(I_PTR_REG_C),
    .i_tags(I_PTR_TAGS), .i_param_block_ptr(I_PARAM_BLOCK_PTR),
    .i_opnd(ins_reg.dst), .o_io_space(dst_io), .o_addr(dst_addr)
  );

  logic              cur_io, cur_bus16, cur_split;
  logic [SYS_AW-1:0] cur_addr;
  logic [DW-1:0]     result;
  logic [7:0]        bmask;

  // next state of the access sequencer
  always_comb begin
    state_next = state_reg;
    ins_next   = ins_reg;
    half_next  = half_reg;
    data_next  = data_reg;
    armed_next = armed_reg;
    req_next   = 1'b0;
    bus_next   = bus_reg;
    jv_next    = 1'b0;
    jt_next    = jt_reg;
    err_next   = err_reg;
    cur_io     = (state_reg == ST_WR) ? dst_io : src_io;
    cur_addr   = (state_reg == ST_WR) ? dst_addr : src_addr;
    cur_bus16  = cur_io ? I_CFG.bus16_io : I_CFG.bus16_sys;
    cur_split  = two_cycles(cur_bus16, ins_reg.word, cur_addr[0]);
    bmask      = 8'h01 << ins_reg.bitsel;
    // combine read data with operand per operation
    case (ins_reg.op)
      CIA_OP_AND:       result = data_reg & ins_reg.imm;
      CIA_OP_OR:        result = data_reg | ins_reg.imm;
      CIA_OP_BIT_CLEAR: result = {8'h00, data_reg[7:0] & ~bmask};
      CIA_OP_BIT_SET:   result = {8'h00, data_reg[7:0] | bmask};
      default:          result = ins_reg.src.valid ? data_reg : ins_reg.imm;
    endcase
    case (state_reg)
      ST_IDLE: begin
        if (I_INSTR_VALID) begin
          ins_next  = I_INSTR;
          half_next = 1'b0;
          data_next = '0;
          if (I_INSTR.op == CIA_OP_ENTER_DMA) begin
            armed_next = 1'b1;
            state_next = ST_IDLE;
          end else if (I_INSTR.src.valid) begin
            state_next = ST_RD;
          end else if (I_INSTR.dst.valid) begin
            state_next = ST_WR;
          end else begin
            state_next = ST_DONE;
          end
        end
      end
      ST_RD, ST_WR: begin
        // issue one bus cycle, low byte first on a split word
        if (!req_reg) begin
          req_next = 1'b1;
          bus_next = mk_req(cur_io, cur_addr + {{(SYS_AW-1){1'b0}}, half_reg},
                            state_reg == ST_WR, cur_bus16, ins_reg.word & ~cur_split,
                            half_reg ? {8'h00, result[15:8]} : result);
          if (cur_io) begin
            bus_next.addr[SYS_AW-1:IO_AW] = '0;
          end
        end else begin
          req_next = 1'b1;
          if (I_BUS_DONE) begin
            req_next = 1'b0;
            if (state_reg == ST_RD) begin
              if (!cur_split) begin
                data_next = (bus_reg.upper) ? {8'h00, I_BUS_RDATA[15:8]}
                          : (ins_reg.word ? I_BUS_RDATA : {8'h00, I_BUS_RDATA[7:0]});
              end else if (!half_reg) begin
                data_next[7:0] = (bus_reg.upper) ? I_BUS_RDATA[15:8] : I_BUS_RDATA[7:0];
              end else begin
                data_next[15:8] = (bus_reg.upper) ? I_BUS_RDATA[15:8] : I_BUS_RDATA[7:0];
              end
            end
            if (cur_split && !half_reg) begin
              half_next = 1'b1;
            end else begin
              half_next  = 1'b0;
              state_next = (state_reg == ST_RD && ins_reg.dst.valid) ? ST_WR : ST_DONE;
            end
          end
        end
      end
      ST_DONE: begin
        // jump test on the byte read
        if (ins_reg.op == CIA_OP_JMP_ONE || ins_reg.op == CIA_OP_JMP_ZERO) begin
          jv_next = 1'b1;
          jt_next = (data_reg[ins_reg.bitsel] == (ins_reg.op == CIA_OP_JMP_ONE));
        end
        if (armed_reg) begin
          armed_next = 1'b0;
          if (I_CFG.bc_term && (I_DMA_COUNT > BC_LIMIT)) begin
            err_next   = 1'b1;
            state_next = ST_ERR;
          end else begin
            state_next = ST_DMA;
          end
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_DMA: begin
        if (I_DMA_DONE) begin
          state_next = ST_IDLE;
        end
      end
      ST_ERR: begin
        err_next   = 1'b0;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_reg <= ST_IDLE;
      ins_reg   <= '0;
      half_reg  <= 1'b0;
      data_reg  <= '0;
      armed_reg <= 1'b0;
      req_reg   <= 1'b0;
      bus_reg   <= '0;
      jv_reg    <= 1'b0;
      jt_reg    <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      ins_reg   <= ins_next;
      half_reg  <= half_next;
      data_reg  <= data_next;
      armed_reg <= armed_next;
      req_reg   <= req_next;
      bus_reg   <= bus_next;
      jv_reg    <= jv_next;
      jt_reg    <= jt_next;
      err_reg   <= err_next;
    end
  end

  // outputs straight from flip-flops
  assign O_INSTR_READY   = state_reg[0];             // idle bit of the one-hot code
  assign O_BUS_REQ       = req_reg;
  assign O_BUS           = bus_reg;
  assign O_JUMP_VALID    = jv_reg;
  assign O_JUMP_TAKEN    = jt_reg;
  assign O_DMA_ACTIVE    = state_reg[4];             // dma bit of the one-hot code
  assign O_DMA_LIMIT_ERR = err_reg;

  // checks on the access sequencer
  a_dma_no_instr: assert property (@(posedge I_CLK) disable iff (I_RST)
    (state_reg == ST_DMA && !I_DMA_DONE) |=> (state_reg == ST_DMA && !O_BUS_REQ))
    else $error("dma mode left early");
  a_io_upper_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_BUS_REQ && O_BUS.io_space) |-> (O_BUS.addr[19:16] == 4'h0))
    else $error("io upper bits set");
  a_pp_system: assert property (@(posedge I_CLK) disable iff (I_RST)
    (state_reg == ST_RD && ins_reg.src.base == BASE_PARAM) |-> !src_io)
    else $error("param pointer went to io");
  a_tag_space: assert property (@(posedge I_CLK) disable iff (I_RST)
    (state_reg == ST_RD && ins_reg.src.base == BASE_A) |-> (src_io == I_PTR_TAGS[0]))
    else $error("tag space wrong");
  a_byte_8bit: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_BUS_REQ && !O_BUS.io_space && !I_CFG.bus16_sys) |-> !O_BUS.word)
    else $error("word cycle on 8-bit bus");
  a_even_word_one: assert property (@(posedge I_CLK) disable iff (I_RST)
    ($rose(O_BUS_REQ) && !half_reg && ins_reg.word && I_CFG.bus16_sys && I_CFG.bus16_io
      && !O_BUS.addr[0]) |-> O_BUS.word) else $error("even word split on 16-bit bus");
  a_dma_after_one: assert property (@(posedge I_CLK) disable iff (I_RST)
    (state_reg == ST_DONE && armed_reg && !I_CFG.bc_term) |=> (state_reg == ST_DMA))
    else $error("dma not entered");
  a_limit_err: assert property (@(posedge I_CLK) disable iff (I_RST)
    (state_reg == ST_DONE && armed_reg && I_CFG.bc_term && I_DMA_COUNT > BC_LIMIT)
      |=> (O_DMA_LIMIT_ERR && !O_DMA_ACTIVE)) else $error("over-limit dma entered");
  a_write_dst: assert property (@(posedge I_CLK) disable iff (I_RST)
    (O_BUS_REQ && O_BUS.write) |-> (state_reg == ST_WR))
    else $error("write outside dest phase");

endmodule : cia_channel_io
`default_nettype wire

// file: hw/cia_pkg.sv
package cia_pkg;

  // address and data widths
  localparam int SYS_AW      = 20;
  localparam int IO_AW       = 16;
  localparam int DW          = 16;
  localparam int BC_W        = 16;
  localparam logic [BC_W:0] BC_LIMIT = 17'h10000; // 64k bytes under byte-count end

  // base register selects
  localparam logic [1:0] BASE_A     = 2'h0;
  localparam logic [1:0] BASE_B     = 2'h1;
  localparam logic [1:0] BASE_C     = 2'h2;
  localparam logic [1:0] BASE_PARAM = 2'h3;

  // operation codes
  typedef enum logic [3:0] {
    CIA_OP_MOVE      = 4'h0,
    CIA_OP_AND       = 4'h1,
    CIA_OP_OR        = 4'h2,
    CIA_OP_BIT_CLEAR = 4'h3,
    CIA_OP_BIT_SET   = 4'h4,
    CIA_OP_JMP_ONE   = 4'h5,
    CIA_OP_JMP_ZERO  = 4'h6,
    CIA_OP_ENTER_DMA = 4'h7
  } cia_op_t;

  // one memory operand reference
  typedef struct packed {
    logic [1:0]        base;    // pointer register select
    logic [SYS_AW-1:0] disp;    // addressing-mode adjustment
    logic              valid;   // operand present
  } cia_opnd_t;

  // one instruction handed to the access path
  typedef struct packed {
    cia_op_t          op;
    logic             word;     // word transfer chosen by opcode
    logic [2:0]       bitsel;   // bit for single-bit ops
    cia_opnd_t        src;
    cia_opnd_t        dst;
    logic [DW-1:0]    imm;      // immediate / mask or write data
  } cia_instr_t;

  // bus cycle request
  typedef struct packed {
    logic              io_space;
    logic [SYS_AW-1:0] addr;
    logic              write;
    logic              upper;   // byte on upper lanes
    logic              word;    // 16-bit cycle
    logic [DW-1:0]     wdata;
  } cia_bus_req_t;

  // channel wide settings
  typedef struct packed {
    logic bus16_sys;            // physical width of system bus
    logic bus16_io;             // physical width of io bus
    logic bc_term;              // byte-count termination chosen
  } cia_cfg_t;

endpackage : cia_pkg

// file: hw/cia_addr_gen.sv
`timescale 1ns/10ps
`default_nettype none
// forms the effective address and space of one operand
module cia_addr_gen (
  input  wire logic [cia_pkg::SYS_AW-1:0] i_ptr_a,
  input  wire logic [cia_pkg::SYS_AW-1:0] i_ptr_b,
  input  wire logic [cia_pkg::SYS_AW-1:0] i_ptr_c,
  input  wire logic [2:0]                 i_tags,
  input  wire logic [cia_pkg::SYS_AW-1:0] i_param_block_ptr,
  input  wire cia_pkg::cia_opnd_t         i_opnd,
  output logic                            o_io_space,
  output logic [cia_pkg::SYS_AW-1:0]      o_addr
);
  import cia_pkg::*;

  logic [SYS_AW-1:0] base;
  logic [SYS_AW-1:0] sum;

  // base pick and space selection
  always_comb begin
    base       = i_param_block_ptr;
    o_io_space = 1'b0;
    case (i_opnd.base)
      BASE_A: begin
        base       = i_ptr_a;
        o_io_space = i_tags[0];
      end
      BASE_B: begin
        base       = i_ptr_b;
        o_io_space = i_tags[1];
      end
      BASE_C: begin
        base       = i_ptr_c;
        o_io_space = i_tags[2];
      end
      default: begin
        base       = i_param_block_ptr;
        o_io_space = 1'b0;
      end
    endcase
    sum = base + i_opnd.disp;
    if (o_io_space) begin
      // io space: low 16 bits only, upper nibble zero
      o_addr = {{(SYS_AW-IO_AW){1'b0}}, base[IO_AW-1:0] + i_opnd.disp[IO_AW-1:0]};
    end else begin
      o_addr = sum;
    end
  end

endmodule : cia_addr_gen
`default_nettype wire

// file: verification/cia_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
// memory and peripheral controllers on the system and io buses
module cia_bus_model
  import cia_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic [3:0]            i_wait,
  input  wire logic                  i_req,
  input  wire cia_pkg::cia_bus_req_t i_bus,
  output logic                       o_done,
  output logic [cia_pkg::DW-1:0]     o_rdata
);
  logic [7:0]  mem [logic [20:0]];
  logic [3:0]  cnt = 4'h0;
  logic [20:0] k;

  // bytes never written read back as a pattern of their address
  function automatic logic [7:0] rd(input logic [20:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h5a);
  endfunction

  // answer a held request after i_wait idle cycles with a one cycle done
  always @(negedge i_clk) begin
    k = {i_bus.io_space, i_bus.addr};
    if (i_rst) begin
      o_done  <= 1'b0;
      cnt     <= 4'h0;
      o_rdata <= 16'h0000;
    end else if (o_done || !i_req) begin
      o_done  <= 1'b0;
      o_rdata <= ~o_rdata; // released lanes flip every cycle
    end else if (cnt != i_wait) begin
      cnt <= cnt + 4'h1;
    end else begin
      o_done <= 1'b1;
      cnt    <= 4'h0;
      if (i_bus.write && i_bus.word) begin
        mem[k]         = i_bus.wdata[7:0];
        mem[k + 21'h1] = i_bus.wdata[15:8];
        o_rdata <= ~o_rdata;
      end else if (i_bus.write) begin
        mem[k] = i_bus.upper ? i_bus.wdata[15:8] : i_bus.wdata[7:0];
        o_rdata <= ~o_rdata;
      end else if (i_bus.word) begin
        o_rdata <= {rd(k + 21'h1), rd(k)};
      end else begin
        // byte device answers on the lanes of its address, other lane junk
        o_rdata <= i_bus.upper ? {rd(k), ~o_rdata[7:0]} : {~o_rdata[15:8], rd(k)};
      end
    end
  end
endmodule // cia_bus_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the channel io access path
module tb_top;
  import cia_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [SYS_AW-1:0]  pa = 20'h12340, pb = 20'hf1000, pc = 20'h0a000, pbp = 20'h23456;
  logic [2:0]         tags = 3'h2; // b in io space
  cia_cfg_t           cfg = '{1'b1, 1'b1, 1'b0};
  logic               ivalid = 1'b0;
  cia_instr_t         instr = '0;
  logic               bdone, ready, breq, jv, jt, dact, derr;
  logic [DW-1:0]      rdata;
  logic               dmadone = 1'b0;
  logic [BC_W:0]      dcount = '0;
  logic [3:0]         wt = 4'h0;
  cia_bus_req_t       bus;
  cia_bus_req_t       cyc_q[$];
  int                 num_errors = 0, check_count = 0, jv_cnt = 0, err_cnt = 0;
  logic               jt_last;

  always #2.5 clk = ~clk;

  cia_channel_io cia_channel_io_i (.I_CLK(clk), .I_RST(rst), .I_PTR_REG_A(pa),
    .I_PTR_REG_B(pb), .I_PTR_REG_C(pc), .I_PTR_TAGS(tags), .I_PARAM_BLOCK_PTR(pbp),
    .I_CFG(cfg), .I_INSTR_VALID(ivalid), .I_INSTR(instr), .I_BUS_DONE(bdone),
    .I_BUS_RDATA(rdata), .I_DMA_DONE(dmadone), .I_DMA_COUNT(dcount),
    .O_INSTR_READY(ready), .O_BUS_REQ(breq), .O_BUS(bus), .O_JUMP_VALID(jv),
    .O_JUMP_TAKEN(jt), .O_DMA_ACTIVE(dact), .O_DMA_LIMIT_ERR(derr));
  cia_bus_model cia_bus_model_i (.i_clk(clk), .i_rst(rst), .i_wait(wt), .i_req(breq),
    .i_bus(bus), .o_done(bdone), .o_rdata(rdata));

  // log finished bus cycles, jump results and limit pulses
  always @(posedge clk) begin
    if (breq === 1'b1 && bdone === 1'b1) cyc_q.push_back(bus);
    if (jv === 1'b1) begin
      jv_cnt++;
      jt_last = jt;
    end
    if (derr === 1'b1) err_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic cia_instr_t mk(cia_op_t op, int w, int bs, int sb, int sd, int sv,
      int db, int dd, int dv, int im);
    return '{op, 1'(w), 3'(bs), '{2'(sb), 20'(sd), 1'(sv)}, '{2'(db), 20'(dd), 1'(dv)}, 16'(im)};
  endfunction

  function automatic logic [7:0] pk(input int io, input logic [19:0] a);
    return cia_bus_model_i.rd({1'(io), a});
  endfunction

  // offer one instruction, then wait for idle or dma mode
  task automatic run(input cia_instr_t ins);
    int n;
    cyc_q.delete();
    @(negedge clk);
    instr  <= ins;
    ivalid <= 1'b1;
    @(negedge clk);
    ivalid <= 1'b0;
    for (n = 0; n < 500 && ready !== 1'b1 && dact !== 1'b1; n++) @(negedge clk);
    check(32'(n == 500), 32'h0);
  endtask

  // operand space, base register, displacement and io address width
  task automatic t_space;
    run(mk(CIA_OP_MOVE, 0, 0, BASE_A, 20'h2, 1, BASE_B, 20'h4, 1, 0));
    check({cyc_q[0].io_space, cyc_q[0].addr, cyc_q[0].write}, {1'b0, 20'h12342, 1'b0});
    check({cyc_q[1].io_space, cyc_q[1].addr, cyc_q[1].write}, {1'b1, 20'h01004, 1'b1});
    check(pk(1, 20'h01004), pk(0, 20'h12342));
    run(mk(CIA_OP_MOVE, 0, 0, BASE_PARAM, 20'h2, 1, BASE_C, 20'h6, 1, 0));
    check({cyc_q[0].io_space, cyc_q[0].addr}, {1'b0, 20'h23458});
    check({cyc_q[1].io_space, cyc_q[1].addr}, {1'b0, 20'h0a006});
    run(mk(CIA_OP_MOVE, 0, 0, BASE_B, 20'hf002, 1, BASE_A, 20'h0, 1, 0));
    check({cyc_q[0].io_space, cyc_q[0].addr}, {1'b1, 20'h00002});
    check({cyc_q[1].io_space, cyc_q[1].addr}, {1'b0, 20'h12340});
    // immediate word written to an even io register, no read phase
    run(mk(CIA_OP_MOVE, 1, 0, BASE_A, 0, 0, BASE_B, 20'h8, 1, 16'hbeef));
    check({30'(cyc_q.size()), cyc_q[0].write, cyc_q[0].word}, {30'h1, 2'h3});
    check({pk(1, 20'h01009), pk(1, 20'h01008)}, 32'hbeef);
    $display("space test done");
  endtask

  // cycles per access over bus width, size and alignment, slow partner
  task automatic t_cycles;
    int n;
    logic w, wd, od;
    logic [15:0] v;
    wt = 4'h2;
    for (int i = 0; i < 8; i++) begin
      {w, wd, od} = 3'(i);
      cfg = '{w, w, 1'b0};
      v = {8'hc3, 8'(i)};
      cia_bus_model_i.mem[{1'b0, 20'h12350 + od}] = v[7:0];
      cia_bus_model_i.mem[{1'b0, 20'h12351 + od}] = v[15:8];
      // byte devices on an 8-bit bus may sit at consecutive addresses
      run(mk(CIA_OP_MOVE, wd, 0, BASE_A, 20'h10 + od, 1, BASE_B, 20'h20 + od, 1, 0));
      n = (wd && (!w || od)) ? 2 : 1;
      check(32'(cyc_q.size()), 32'(2 * n));
      check(32'(cyc_q[0].word), 32'(w & wd & ~od));
      check(cyc_q[0].addr, 20'h12350 + od);
      if (w) check(32'(cyc_q[0].upper), 32'(od));
      if (n == 2) check(cyc_q[1].addr, 20'h12351 + od);
      check(pk(1, 20'h01020 + od), v[7:0]);
      if (wd) check(pk(1, 20'h01021 + od), v[15:8]);
    end
    wt = 4'h0;
    cfg = '{1'b1, 1'b1, 1'b0};
    $display("cycles test done");
  endtask

  // read-modify-write ops on an odd byte register, then jumps on its bits
  task automatic t_ops;
    cia_op_t ops[4] = '{CIA_OP_AND, CIA_OP_OR, CIA_OP_BIT_CLEAR, CIA_OP_BIT_SET};
    logic [15:0] ims[4] = '{16'h0f, 16'hf0, 16'h0, 16'h0};
    logic [2:0] bss[4] = '{3'h0, 3'h0, 3'h1, 3'h0};
    logic [7:0] exp[4] = '{8'h0a, 8'hfa, 8'hf8, 8'hf9};
    cia_op_t jo[4] = '{CIA_OP_JMP_ONE, CIA_OP_JMP_ZERO, CIA_OP_JMP_ONE, CIA_OP_JMP_ZERO};
    // registers of a byte device on a 16-bit bus two apart
    cia_bus_model_i.mem[{1'b1, 20'h01031}] = 8'h5a;
    for (int i = 0; i < 4; i++) begin
      run(mk(ops[i], 0, bss[i], BASE_B, 20'h31, 1, BASE_B, 20'h31, 1, ims[i]));
      check({30'(cyc_q.size()), cyc_q[1].write, cyc_q[1].upper}, {30'h2, 2'h3});
      check(pk(1, 20'h01031), exp[i]);
    end
    for (int i = 0; i < 4; i++) begin
      run(mk(jo[i], 0, 3'(i), BASE_B, 20'h31, 1, BASE_B, 20'h0, 0, 0));
      repeat (2) @(negedge clk);
      check({31'(cyc_q.size()), cyc_q[0].write}, {31'h1, 1'b0});
      check({31'(jv_cnt), jt_last}, {31'(i + 1), i < 2});
    end
    $display("ops test done");
  endtask

  // dma entry, one following instruction, limit and blocked instructions
  task automatic t_dma;
    logic [17:0] rows[3] = '{{1'b0, 17'h1ffff}, {1'b1, 17'h10000}, {1'b1, 17'h10001}};
    int e;
    for (int i = 0; i < 3; i++) begin
      cfg.bc_term = rows[i][17];
      dcount = rows[i][16:0];
      e = err_cnt;
      run(mk(CIA_OP_ENTER_DMA, 0, 0, BASE_A, 0, 0, BASE_A, 0, 0, 0));
      check({30'(cyc_q.size()), ready, dact}, {30'h0, 2'h2});
      // the parameter that starts the controller follows entry
      run(mk(CIA_OP_MOVE, 0, 0, BASE_A, 20'h0, 1, BASE_B, 20'h40, 1, 0));
      repeat (2) @(negedge clk);
      check({31'(cyc_q.size()), dact}, {31'h2, i < 2});
      check(32'(err_cnt - e), 32'(i == 2));
      if (dact === 1'b1) begin
        cyc_q.delete();
        instr  <= mk(CIA_OP_MOVE, 0, 0, BASE_A, 20'h0, 1, BASE_B, 20'h40, 1, 0);
        ivalid <= 1'b1;
        repeat (4) @(negedge clk);
        ivalid <= 1'b0;
        check({31'(cyc_q.size()), ready}, {31'h0, 1'b0});
        dmadone <= 1'b1;
        @(negedge clk);
        dmadone <= 1'b0;
        repeat (3) @(negedge clk);
        check({ready, dact}, 2'h2);
      end
    end
    $display("dma test done");
  endtask

  initial begin
    #100000;
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (3) @(negedge clk);
    rst <= 1'b0;
    t_space();
    t_cycles();
    t_ops();
    t_dma();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
